// file: logic/lerc_top.sv
/*
 * Programmable register of one logic element with its asynchronous
 * clear, preset and load steering, six dedicated low-skew inputs, a
 * chip-wide reset and an AHB-Lite register port for configuration.
 * Assumes lab control lines and data come from logic on core_clk;
 * dedicated and chip reset pins are asynchronous and are synchronised.
 */
// Local design decisions: the AHB-Lite interface to the registers and the register offsets.
// Function
// RULE_01: Async clear mode: line A or line B clears, preset held inactive.
// RULE_02: Async preset either by loading a tied-high input or by inverted clear.
// RULE_03: Input inversion for logic and io elements; inverted preset frees load input.
// RULE_04: Preset and clear mode: line A loads a one, line B clears.
// RULE_05: Load with clear: line A loads input via preset and clear; B clears.
// RULE_06: Load with preset: inverted register; line B presets, line A loads.
// RULE_07: Load with preset inverts the load input so output shows true value.
// RULE_08: Load only: line A loads input via preset and clear.
// RULE_09: Six dedicated inputs serve as controls or, slower, as data.
// RULE_10: Register clear and preset active low; unused ones held high.
// RULE_11: Enabled chip-wide reset overrides every clear, preset and load.
// RULE_12: Register captures data on clock edge; async controls act at once.
`timescale 1ns/1ns
module lerc_top (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Element inputs
	input wire logic lab_control_line_a,
	input wire logic lab_control_line_b,
	input wire logic element_load_input,
	input wire logic register_data_input,
	input wire logic io_element_input,
	// Device pins
	input wire logic [lerc_pkg::LERC_NUM_DEDICATED-1:0] dedicated_in,
	input wire logic chip_reset_pin,
	// Element outputs
	output logic register_out,
	output logic register_clear_low,
	output logic register_preset_low,
	output logic io_element_value,
	output logic [lerc_pkg::LERC_NUM_DEDICATED-1:0] dedicated_data
);
	import lerc_pkg::*;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [LERC_NUM_DEDICATED-1:0] ded_meta_reg;
	logic [LERC_NUM_DEDICATED-1:0] ded_sync_reg;
	logic chip_reset_meta_reg;
	logic chip_reset_sync_reg;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ded_meta_reg <= '0;
			ded_sync_reg <= '0;
			chip_reset_meta_reg <= 1'b0;
			chip_reset_sync_reg <= 1'b0;
		end else begin
			ded_meta_reg <= dedicated_in;
			ded_sync_reg <= ded_meta_reg;
			chip_reset_meta_reg <= chip_reset_pin;
			chip_reset_sync_reg <= chip_reset_meta_reg;
		end
	end

	// Dedicated inputs also usable as plain data
	assign dedicated_data = ded_sync_reg; // [RULE_09]

	// ----------------------------------------------------------------
	// AHB-Lite register port
	// ----------------------------------------------------------------
	logic [LERC_CTRL_W-1:0] ctrl_reg;
	logic [7:0] addr_reg;
	logic wr_pend_reg;
	logic [31:0] rdata_reg;
	logic [31:0] status_word;
	logic addr_phase;

	assign addr_phase = hsel && htrans[1] && hready;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = rdata_reg;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			addr_reg <= 8'h00;
			wr_pend_reg <= 1'b0;
		end else begin
			wr_pend_reg <= addr_phase && hwrite;
			if (addr_phase) begin
				addr_reg <= haddr[7:0];
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ctrl_reg <= LERC_CTRL_RST[LERC_CTRL_W-1:0];
		end else if (wr_pend_reg && addr_reg == LERC_CTRL_OFS) begin
			ctrl_reg <= hwdata[LERC_CTRL_W-1:0];
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rdata_reg <= 32'h00000000;
		end else if (addr_phase && !hwrite) begin
			if (haddr[7:0] == LERC_CTRL_OFS) begin
				rdata_reg <= {{(32-LERC_CTRL_W){1'b0}}, ctrl_reg};
			end else if (haddr[7:0] == LERC_STATUS_OFS) begin
				rdata_reg <= status_word;
			end else begin
				rdata_reg <= 32'h00000000;
			end
		end
	end

	// ----------------------------------------------------------------
	// Control decode and source selection
	// ----------------------------------------------------------------
	lerc_mode_t mode;
	logic chip_reset_en;
	logic data_inv;
	logic io_inv;
	logic ctl_a;
	logic ctl_b;
	logic reg_inverted;
	logic chip_reset_act;

	always_comb begin
		case (ctrl_reg[LERC_MODE_LSB +: LERC_MODE_W])
			3'h0: mode = LERC_ACLR;
			3'h1: mode = LERC_APRE_LOAD;
			3'h2: mode = LERC_APRE_INV;
			3'h3: mode = LERC_PRE_CLR;
			3'h4: mode = LERC_LOAD_CLR;
			3'h5: mode = LERC_LOAD_PRE;
			default: mode = LERC_LOAD_ONLY;
		endcase
	end

	assign chip_reset_en = ctrl_reg[LERC_RESET_EN_BIT];
	assign data_inv = ctrl_reg[LERC_DATA_INV_BIT];
	assign io_inv = ctrl_reg[LERC_IO_INV_BIT];
	assign chip_reset_act = chip_reset_en && chip_reset_sync_reg;

	// Index above five selects the user line
	function automatic logic pick_src(input logic ded, input logic [LERC_IDX_W-1:0] idx,
		input logic user, input logic [LERC_NUM_DEDICATED-1:0] pins);
		logic v;
		v = user;
		if (ded && idx < LERC_IDX_W'(LERC_NUM_DEDICATED)) begin
			v = pins[idx];
		end
		return v;
	endfunction

	assign ctl_a = pick_src(ctrl_reg[LERC_SRC_A_DED_BIT], ctrl_reg[LERC_SRC_A_IDX_LSB +: LERC_IDX_W],
		lab_control_line_a, ded_sync_reg); // [RULE_09]
	assign ctl_b = pick_src(ctrl_reg[LERC_SRC_B_DED_BIT], ctrl_reg[LERC_SRC_B_IDX_LSB +: LERC_IDX_W],
		lab_control_line_b, ded_sync_reg); // [RULE_09]

	// Input inversion for logic and io elements
	assign io_element_value = io_element_input ^ io_inv; // [RULE_03]

	// ----------------------------------------------------------------
	// Clear and preset steering
	// ----------------------------------------------------------------
	logic clr_act;
	logic pre_act;

	always_comb begin
		clr_act = 1'b0;
		pre_act = 1'b0;
		reg_inverted = 1'b0;
		unique case (mode)
			LERC_ACLR: begin
				clr_act = ctl_a || ctl_b; // [RULE_01]
			end
			LERC_APRE_LOAD: begin
				pre_act = ctl_a; // [RULE_02]
			end
			LERC_APRE_INV: begin
				reg_inverted = 1'b1;
				clr_act = ctl_a; // [RULE_02] [RULE_03]
			end
			LERC_PRE_CLR: begin
				pre_act = ctl_a; // [RULE_04]
				clr_act = ctl_b;
			end
			LERC_LOAD_CLR: begin
				pre_act = ctl_a && element_load_input; // [RULE_05]
				clr_act = (ctl_a && !element_load_input) || ctl_b;
			end
			LERC_LOAD_PRE: begin
				reg_inverted = 1'b1;
				pre_act = ctl_a && !element_load_input; // [RULE_06] [RULE_07]
				clr_act = (ctl_a && element_load_input) || ctl_b;
			end
			LERC_LOAD_ONLY: begin
				pre_act = ctl_a && element_load_input; // [RULE_08]
				clr_act = ctl_a && !element_load_input;
			end
		endcase
		if (chip_reset_act) begin
			clr_act = 1'b1; // [RULE_11]
			pre_act = 1'b0;
		end
	end

	// Active low, high when unused
	assign register_clear_low = !clr_act; // [RULE_10]
	assign register_preset_low = !pre_act; // [RULE_10]

	// ----------------------------------------------------------------
	// Programmable register
	// ----------------------------------------------------------------
	logic q_reg;
	logic q_next;
	logic reg_clr_n;
	logic reg_pre_n;

	assign reg_clr_n = register_clear_low && !rst;
	assign reg_pre_n = register_preset_low || !reg_clr_n; // Preset edge only once clear is gone [RULE_12]
	assign q_next = register_data_input ^ data_inv ^ reg_inverted;

	always_ff @(posedge core_clk or negedge reg_clr_n or negedge reg_pre_n) begin
		if (!reg_clr_n) begin
			q_reg <= 1'b0; // [RULE_11] [RULE_12]
		end else if (!reg_pre_n) begin
			q_reg <= 1'b1; // [RULE_12]
		end else begin
			q_reg <= q_next; // [RULE_12]
		end
	end

	// Output inversion restores the true value
	assign register_out = q_reg ^ reg_inverted; // [RULE_06] [RULE_07]

	assign status_word = {{(32-LERC_ST_DED_LSB-LERC_NUM_DEDICATED){1'b0}}, ded_sync_reg,
		register_preset_low, register_clear_low, register_out};

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	AST_ACLR: assert property (@(posedge core_clk) disable iff (rst) // [RULE_01]
		(mode == LERC_ACLR && !chip_reset_act) |-> (register_preset_low && register_clear_low == !(ctl_a || ctl_b)))
		else $error("clear mode steering wrong");
	AST_APRE_INV: assert property (@(posedge core_clk) disable iff (rst) // [RULE_02]
		(mode == LERC_APRE_INV && ctl_a && !chip_reset_act) |-> register_out)
		else $error("inverted preset did not give one");
	AST_PRE_CLR: assert property (@(posedge core_clk) disable iff (rst) // [RULE_04]
		(mode == LERC_PRE_CLR && ctl_a && !ctl_b && !chip_reset_act) |-> register_out)
		else $error("preset via load failed");
	AST_LOAD_CLR: assert property (@(posedge core_clk) disable iff (rst) // [RULE_05]
		(mode == LERC_LOAD_CLR && !chip_reset_act && ctl_b) |-> (!register_clear_low && !register_out))
		else $error("line b did not clear");
	AST_LOAD_PRE: assert property (@(posedge core_clk) disable iff (rst) // [RULE_06]
		(mode == LERC_LOAD_PRE && !chip_reset_act && ctl_b) |-> register_out)
		else $error("line b did not preset");
	AST_LOAD_VAL: assert property (@(posedge core_clk) disable iff (rst) // [RULE_07]
		((mode == LERC_LOAD_PRE || mode == LERC_LOAD_ONLY) && ctl_a && !ctl_b && !chip_reset_act)
		|-> register_out == element_load_input)
		else $error("async load value wrong");
	AST_LOAD_ONLY: assert property (@(posedge core_clk) disable iff (rst) // [RULE_08]
		(mode == LERC_LOAD_ONLY && !ctl_a && !chip_reset_act) |-> (register_clear_low && register_preset_low))
		else $error("load only drove control while idle");
	AST_DED_DATA: assert property (@(posedge core_clk) disable iff (rst) // [RULE_09]
		##2 dedicated_data == $past(dedicated_in, 2))
		else $error("dedicated data path delay wrong");
	AST_ACTIVE_LOW: assert property (@(posedge core_clk) disable iff (rst) // [RULE_10]
		!(register_clear_low || register_preset_low) |-> ctl_b && mode inside {[LERC_PRE_CLR:LERC_LOAD_PRE]})
		else $error("clear and preset both low");
	AST_CHIP_RESET: assert property (@(posedge core_clk) disable iff (rst) // [RULE_11]
		(chip_reset_act) |-> (!register_clear_low && register_preset_low && register_out == reg_inverted))
		else $error("chip reset did not override");
	AST_CAPTURE: assert property (@(posedge core_clk) disable iff (rst) // [RULE_12]
		(register_clear_low && register_preset_low) ##1 (register_clear_low && register_preset_low)
		|-> q_reg == $past(q_next))
		else $error("register did not capture data");

endmodule

// file: logic/lerc_pkg.sv
/*
 * Constants for the logic element register clear, preset and load control.
 * Assumes a single 32-bit AHB-Lite slave port and word-aligned registers.
 */
package lerc_pkg;

	// ----------------------------------------------------------------
	// Configurations of the asynchronous control
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		LERC_ACLR,
		LERC_APRE_LOAD,
		LERC_APRE_INV,
		LERC_PRE_CLR,
		LERC_LOAD_CLR,
		LERC_LOAD_PRE,
		LERC_LOAD_ONLY
	} lerc_mode_t;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] LERC_CTRL_OFS = 8'h00;
	localparam logic [7:0] LERC_STATUS_OFS = 8'h04;
	localparam logic [31:0] LERC_CTRL_RST = 32'h00000000;

	// Control fields
	localparam int LERC_MODE_LSB = 0;
	localparam int LERC_MODE_W = 3;
	localparam int LERC_RESET_EN_BIT = 3;
	localparam int LERC_DATA_INV_BIT = 4;
	localparam int LERC_IO_INV_BIT = 5;
	localparam int LERC_SRC_A_DED_BIT = 6;
	localparam int LERC_SRC_A_IDX_LSB = 7;
	localparam int LERC_SRC_B_DED_BIT = 10;
	localparam int LERC_SRC_B_IDX_LSB = 11;
	localparam int LERC_IDX_W = 3;
	localparam int LERC_CTRL_W = 14;

	// Status fields
	localparam int LERC_ST_Q_BIT = 0;
	localparam int LERC_ST_CLR_BIT = 1;
	localparam int LERC_ST_PRE_BIT = 2;
	localparam int LERC_ST_DED_LSB = 3;

	// Count of dedicated low-skew inputs
	localparam int LERC_NUM_DEDICATED = 6;

endpackage

// file: bench/lerc_user_model.sv
/*
 * Model of the user logic that drives the lab control lines and load data.
 * Assumes the bench asks for levels just after a rising edge of core_clk.
 */
`timescale 1ns/1ns
module lerc_user_model (
	// Clock
	input wire logic core_clk,
	// Requested levels
	input wire logic want_a,
	input wire logic want_b,
	input wire logic want_load,
	// Towards the element
	output logic lab_control_line_a,
	output logic lab_control_line_b,
	output logic element_load_input
);
	// ----------------------------------------------------------------
	// Registered launch, as real user logic
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		lab_control_line_a <= want_a;
		lab_control_line_b <= want_b;
		element_load_input <= want_load;
	end
endmodule

// file: bench/tb_top.sv
/*
 * Self-checking bench for the element register control block.
 * Assumes a zero-wait AHB-Lite slave and the user model on the lab lines.
 */
`timescale 1ns/1ns
module tb_top;
	import lerc_pkg::*;
	logic core_clk, rst, hsel, hwrite, hready, hreadyout, hresp;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic a, b, ld, want_a, want_b, want_ld, rdin, ioin, io_val, chip_rst, q, clr_low, pre_low;
	logic [5:0] ded_in, ded_out;
	int miscompares, checked;
	assign hready = hreadyout;

	lerc_top DUT (.core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .lab_control_line_a(a), .lab_control_line_b(b),
		.element_load_input(ld), .register_data_input(rdin), .io_element_input(ioin),
		.dedicated_in(ded_in), .chip_reset_pin(chip_rst), .register_out(q),
		.register_clear_low(clr_low), .register_preset_low(pre_low), .io_element_value(io_val),
		.dedicated_data(ded_out));

	lerc_user_model user (.core_clk(core_clk), .want_a(want_a), .want_b(want_b), .want_load(want_ld),
		.lab_control_line_a(a), .lab_control_line_b(b), .element_load_input(ld));

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic end_sim;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wait_ready;
		int n;
		for (n = 0; n < 50; n++) begin
			@(posedge core_clk);
			if (hready === 1'b1) break;
		end
		if (n == 50) begin
			miscompares++;
			end_sim();
		end
	endtask

	task automatic xfer(input logic w, input logic [31:0] adr, input logic [31:0] d);
		@(posedge core_clk);
		hsel <= 1'b1;
		haddr <= adr;
		hwrite <= w;
		htrans <= 2'b10;
		wait_ready();
		htrans <= 2'b00;
		hwdata <= d;
		wait_ready();
		rd = hrdata;
		hsel <= 1'b0;
	endtask

	// Lines idle before the configuration changes
	task automatic mode(input logic [31:0] c);
		@(posedge core_clk);
		{want_a, want_b, want_ld} <= 3'b000;
		xfer(1'b1, 32'h0, c);
	endtask

	// Expected is {register_out, clear_low, preset_low}
	task automatic el(input logic [2:0] abl, input logic [2:0] exp);
		@(posedge core_clk);
		{want_a, want_b, want_ld} <= abl;
		repeat (2) @(posedge core_clk);
		@(negedge core_clk);
		chk({29'h0, q, clr_low, pre_low}, {29'h0, exp});
	endtask

	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	initial begin
		rst = 1'b1;
		{hsel, hwrite, htrans, haddr, hwdata} = '0;
		hsize = 3'h2;
		{want_a, want_b, want_ld, rdin, ioin, chip_rst} = '0;
		ded_in = 6'h00;
		miscompares = 0;
		checked = 0;
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		rdin <= 1'b1;
		el(3'b000, 3'b111);
		el(3'b100, 3'b001);
		el(3'b000, 3'b111);
		el(3'b010, 3'b001);
		$display("test clear modes done");
		mode(32'(LERC_APRE_LOAD));
		el(3'b100, 3'b110);
		mode(32'(LERC_APRE_INV));
		el(3'b100, 3'b101);
		mode(32'(LERC_PRE_CLR));
		el(3'b100, 3'b110);
		el(3'b010, 3'b001);
		mode(32'(LERC_LOAD_CLR));
		el(3'b100, 3'b001);
		el(3'b101, 3'b110);
		el(3'b111, 3'b000);
		el(3'b010, 3'b001);
		mode(32'(LERC_LOAD_PRE));
		el(3'b010, 3'b101);
		el(3'b101, 3'b101);
		el(3'b100, 3'b010);
		mode(32'(LERC_LOAD_ONLY));
		el(3'b101, 3'b110);
		el(3'b100, 3'b001);
		$display("test load modes done");
		mode(32'h20);
		@(posedge core_clk);
		ioin <= 1'b1;
		@(negedge core_clk);
		chk({31'h0, io_val}, 32'h0);
		mode(32'h10);
		el(3'b000, 3'b011);
		$display("test io inversion done");
		mode(32'h140);
		@(posedge core_clk);
		ded_in <= 6'h04;
		el(3'b000, 3'b001);
		chk({26'h0, ded_out}, 32'h04);
		xfer(1'b0, 32'h04, 32'h0);
		chk({23'h0, rd[8:0]}, 32'h24);
		chk({31'h0, hresp}, 32'h0);
		xfer(1'b1, 32'h08, 32'hFF);
		xfer(1'b0, 32'h08, 32'h0);
		chk(rd, 32'h0);
		xfer(1'b0, 32'h00, 32'h0);
		chk(rd, 32'h140);
		$display("test dedicated inputs done");
		mode(32'h04);
		@(posedge core_clk);
		chip_rst <= 1'b1;
		ded_in <= 6'h00;
		el(3'b101, 3'b110);
		mode(32'h0C);
		el(3'b101, 3'b001);
		$display("test chip reset done");
		end_sim();
	end
endmodule
